/* File: shared/lscu_pkg.sv */
// Constants, types and field layout for the LCD serial command unit.
// Assumes a single 25 MHz system clock; serial pins are sampled as sync.
// Contract
// - Clear-cursor-blink command stops cursor blink at the pointer location.
// - Clear-cursor-blink is accepted where the cursor is off, no error.
// - Combined set command enables character and cursor blink together.
// - Combined clear command cancels character and cursor blink together.
// - Pointer advances by one after data bytes and the listed commands.
// - Chip select assertion aligns receiver to bytes; bytes may follow freely.
// - Each command completes within two common-line display periods.
// - With serial output enabled, the code at the pointer shifts out.
// - Interrupted reads resume unfinished bits; extra bits read as zero.
// - External clock source divides oscillator input by the divide field.
// - Frame rate scales with internal logic clock relative to 32.768 kHz.
// - Standby is entered on reset pin or on the stop command.
// - Reset entry loads minimum contrast; stop entry keeps prior contrast.
// - All other state is kept across stop-command standby; reset entry reloads the registers and keeps only the cell memory.
// - Any byte with bit zero set releases standby and is executed.
// - Blinking character alternates between its glyph and all dots off.
// - Top two bits set loads bits five to zero into the pointer.
// - Frequency field codes select division by two, four, eight, sixteen.
// - Stop command halts oscillator, drives outputs to supply, enters standby.
package lscu_pkg;

	localparam int ADDR_W = 6;
	localparam int DEPTH = 64;
	localparam int BYTE_W = 8;
	localparam int FIELD_LO = 1;
	localparam int FIELD_HI = 3;
	localparam logic [2:0] OP_CHB_SET = 3'h0;
	localparam logic [2:0] OP_CHB_CLR = 3'h1;
	localparam logic [2:0] OP_CUR_ON = 3'h2;
	localparam logic [2:0] OP_CUR_OFF = 3'h3;
	localparam logic [2:0] OP_CSB_SET = 3'h4;
	localparam logic [2:0] OP_CSB_CLR = 3'h5;
	localparam logic [2:0] OP_BOTH_SET = 3'h6;
	localparam logic [2:0] OP_BOTH_CLR = 3'h7;
	localparam logic [7:0] CMD_STOP = 8'h84;
	localparam logic [7:0] MASK_STOP = 8'he7;
	localparam logic [7:0] CMD_SF = 8'ha0;
	localparam logic [7:0] MASK_SF = 8'hf0;
	localparam logic [7:0] CMD_LOT = 8'hb0;
	localparam logic [7:0] CMD_BANK = 8'h80;
	localparam logic [7:0] MASK_BANK = 8'hee;
	localparam logic [7:0] CMD_CONT = 8'h82;
	localparam logic [7:0] CMD_SOE = 8'h86;
	localparam logic [7:0] CMD_DISP = 8'h88;
	localparam logic [7:0] MASK_ONE = 8'hee;
	localparam logic [7:0] CMD_POINTER_INCREMENT_CMD = 8'h8a;
	localparam logic [7:0] MASK_POINTER_INCREMENT_CMD = 8'hea;
	localparam logic [7:0] BLANK_CODE = 8'h20;
	localparam logic [1:0] DIV_RESET = 2'h3;
	localparam logic [2:0] CONTRAST_MIN = 3'h0;
	// One common line is 256 internal ticks at 32.768 kHz frame timing.
	localparam int LINE_TICKS = 256;
	localparam int EXEC_LINES = 2;
	localparam int EXEC_TICKS = LINE_TICKS * EXEC_LINES;
	localparam int BLINK_TICKS = 16384;

	typedef struct packed {
		logic chb;
		logic cur;
		logic csb;
	} lscu_attr_t;

	typedef struct packed {
		logic [7:0] code;
		lscu_attr_t attr;
	} lscu_cell_t;

endpackage

/* File: hdl/lscu_cell_ram.sv */
// Cell memory: code and attribute bits for each display location.
// Assumes one write and one registered read per clock.
`timescale 1ns/1ps
module lscu_cell_ram #(
	parameter int DEPTH = lscu_pkg::DEPTH,
	parameter int AW = lscu_pkg::ADDR_W
)
(
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire lscu_pkg::lscu_cell_t wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output lscu_pkg::lscu_cell_t rdata_o
);
	lscu_pkg::lscu_cell_t mem [DEPTH];

	// No reset so the array maps onto plain memory; contents persist.
	always_ff @(posedge clk_i)
	begin
		if (we_i)
		begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule // lscu_cell_ram

/* File: hdl/lscu_clk_div.sv */
// Internal tick generator: divides the oscillator input tick.
// Assumes osc_tick_i is a one-cycle pulse per oscillator period.
`timescale 1ns/1ps
module lscu_clk_div (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic osc_tick_i,
	input wire logic ext_sel_i,
	input wire logic [1:0] div_i,
	input wire logic run_i,
	output logic tick_o
);
	typedef struct packed {
		logic [3:0] cnt;
		logic tick;
	} lscu_div_st_t;

	lscu_div_st_t st_reg;
	lscu_div_st_t st_next;
	logic [3:0] last;

	always_comb
	begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		// Divide by 2, 4, 8 or 16 for codes 0 to 3.
		last = 4'((5'h2 << div_i) - 5'h1);
		if (run_i && osc_tick_i)
		begin
			if (!ext_sel_i)
			begin
				st_next.tick = 1'b1;
			end
			else if (st_reg.cnt >= last)
			begin
				st_next.cnt = 4'h0;
				st_next.tick = 1'b1;
			end
			else
			begin
				st_next.cnt = st_reg.cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign tick_o = st_reg.tick;
endmodule // lscu_clk_div

/* File: hdl/lscu_top.sv */
// Serial command front end: byte receiver, decoder, pointer, read-out.
// Assumes serial inputs synchronous to clk_i and sampled on sclk rise.
`timescale 1ns/1ps
module lscu_top #(
	parameter int EXEC_TICKS = lscu_pkg::EXEC_TICKS,
	parameter int BLINK_TICKS = lscu_pkg::BLINK_TICKS
)
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic cs_i,
	input wire logic sclk_i,
	input wire logic sdata_i,
	input wire logic cmd_sel_i,
	input wire logic osc_tick_i,
	input wire logic clock_source_select_i,
	input wire logic [1:0] contrast_offset_i,
	output logic sout_o,
	output logic sout_oe_o,
	output logic busy_o,
	output logic standby_o,
	output logic osc_run_o,
	output logic display_on_o,
	output logic bank_o,
	output logic [3:0] contrast_o,
	output logic blink_phase_o,
	output logic [lscu_pkg::ADDR_W-1:0] pointer_o
);
	typedef enum logic [1:0] {IDLE, EXEC, WAITX} lscu_state_t;

	typedef struct packed {
		lscu_state_t state;
		logic sclk_d;
		logic [2:0] bit_cnt;
		logic [7:0] shreg;
		logic [7:0] byte_q;
		logic is_cmd;
		logic [lscu_pkg::ADDR_W-1:0] ptr;
		logic [1:0] div;
		logic [1:0] lot;
		logic [2:0] contrast;
		logic standby;
		logic disp;
		logic bank;
		logic serial_output_enable_cmd;
		logic [7:0] out_sh;
		logic [3:0] out_left;
		logic [15:0] exec_cnt;
		logic [15:0] blink_cnt;
		logic blink_ph;
		logic sout;
	} lscu_st_t;

	lscu_st_t st_reg;
	lscu_st_t st_next;
	lscu_pkg::lscu_cell_t rd_cell;
	lscu_pkg::lscu_cell_t wr_cell;
	logic we;
	logic tick;
	logic rise;
	logic fall;
	logic [7:0] b;

	lscu_clk_div u_div (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.osc_tick_i(osc_tick_i),
		.ext_sel_i(!clock_source_select_i),
		.div_i(st_reg.div),
		.run_i(!st_reg.standby),
		.tick_o(tick)
	);

	lscu_cell_ram u_ram (
		.clk_i(clk_i),
		.we_i(we),
		.waddr_i(st_reg.ptr),
		.wdata_i(wr_cell),
		.raddr_i(st_reg.ptr),
		.rdata_o(rd_cell)
	);

	always_comb
	begin
		st_next = st_reg;
		we = 1'b0;
		wr_cell = rd_cell;
		b = st_reg.byte_q;
		st_next.sclk_d = sclk_i;
		rise = sclk_i && !st_reg.sclk_d && cs_i;
		fall = !sclk_i && st_reg.sclk_d && cs_i;
		if (!cs_i)
		begin
			st_next.bit_cnt = 3'h0;
		end
		else if (rise && st_reg.state == IDLE)
		begin
			st_next.shreg = {st_reg.shreg[6:0], sdata_i};
			st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
			if (st_reg.bit_cnt == 3'h7)
			begin
				st_next.byte_q = {st_reg.shreg[6:0], sdata_i};
				st_next.is_cmd = cmd_sel_i;
				st_next.state = EXEC;
			end
		end
		// Read-out keeps its unfinished bits across a chip select drop.
		if (fall && st_reg.serial_output_enable_cmd)
		begin
			st_next.sout = st_reg.out_sh[7];
			st_next.out_sh = {st_reg.out_sh[6:0], 1'b0};
			if (st_reg.out_left != 4'h0)
			begin
				st_next.out_left = st_reg.out_left - 4'h1;
			end
		end
		if (tick)
		begin
			if (st_reg.blink_cnt >= 16'(BLINK_TICKS / 2 - 1))
			begin
				st_next.blink_cnt = 16'h0;
				st_next.blink_ph = !st_reg.blink_ph;
			end
			else
			begin
				st_next.blink_cnt = st_reg.blink_cnt + 16'h1;
			end
		end
		case (st_reg.state)
			IDLE:
			begin
			end
			EXEC:
			begin
				st_next.state = WAITX;
				st_next.exec_cnt = 16'h0;
				if (b[0])
				begin
					st_next.standby = 1'b0;
				end
				if (!st_reg.is_cmd)
				begin
					we = 1'b1;
					wr_cell.code = b;
					st_next.ptr = st_reg.ptr + 1'b1;
				end
				else if (b[7:6] == 2'h3)
				begin
					st_next.ptr = b[5:0];
				end
				else if (!b[7])
				begin
					we = 1'b1;
					case (b[3:1])
						lscu_pkg::OP_CHB_SET: wr_cell.attr.chb = 1'b1;
						lscu_pkg::OP_CHB_CLR: wr_cell.attr.chb = 1'b0;
						lscu_pkg::OP_CUR_ON: wr_cell.attr.cur = 1'b1;
						lscu_pkg::OP_CUR_OFF: wr_cell.attr.cur = 1'b0;
						lscu_pkg::OP_CSB_SET: wr_cell.attr.csb = 1'b1;
						// Accepted regardless of the cursor bit.
						lscu_pkg::OP_CSB_CLR: wr_cell.attr.csb = 1'b0;
						// The cursor-on bit is left alone by both combined commands.
						lscu_pkg::OP_BOTH_SET:
						begin
							wr_cell.attr.chb = 1'b1;
							wr_cell.attr.csb = 1'b1;
						end
						lscu_pkg::OP_BOTH_CLR:
						begin
							wr_cell.attr.chb = 1'b0;
							wr_cell.attr.csb = 1'b0;
						end
						default: wr_cell = rd_cell;
					endcase
					st_next.ptr = st_reg.ptr + 1'b1;
				end
				else if ((b & lscu_pkg::MASK_POINTER_INCREMENT_CMD) == lscu_pkg::CMD_POINTER_INCREMENT_CMD)
				begin
					we = st_reg.lot != 2'h0;
					if (st_reg.lot[1])
					begin
						wr_cell.attr = '0;
					end
					if (st_reg.lot[0])
					begin
						wr_cell.code = lscu_pkg::BLANK_CODE;
					end
					st_next.ptr = st_reg.ptr + 1'b1;
				end
				else if ((b & lscu_pkg::MASK_SF) == lscu_pkg::CMD_SF)
				begin
					st_next.div = b[1:0];
				end
				else if ((b & lscu_pkg::MASK_SF) == lscu_pkg::CMD_LOT)
				begin
					st_next.lot = b[1:0];
				end
				else if ((b & lscu_pkg::MASK_STOP) == lscu_pkg::CMD_STOP)
				begin
					st_next.standby = 1'b1;
				end
				else if ((b & lscu_pkg::MASK_BANK) == lscu_pkg::CMD_BANK)
				begin
					st_next.bank = b[0];
				end
				else if ((b & lscu_pkg::MASK_ONE) == lscu_pkg::CMD_CONT)
				begin
					st_next.contrast = b[0] ? st_reg.contrast + 3'h1
						: st_reg.contrast - 3'h1;
				end
				else if ((b & lscu_pkg::MASK_ONE) == lscu_pkg::CMD_SOE)
				begin
					st_next.serial_output_enable_cmd = b[0];
				end
				else if ((b & lscu_pkg::MASK_ONE) == lscu_pkg::CMD_DISP)
				begin
					st_next.disp = b[0];
				end
			end
			WAITX:
			begin
				// Completion is counted in internal ticks; the host waits longer.
				if (st_reg.exec_cnt >= 16'(EXEC_TICKS - 1) || st_reg.standby)
				begin
					st_next.state = IDLE;
					st_next.bit_cnt = 3'h0;
					if (st_reg.serial_output_enable_cmd && st_reg.out_left == 4'h0)
					begin
						st_next.out_sh = rd_cell.code;
						st_next.out_left = 4'h8;
					end
				end
				else if (tick)
				begin
					st_next.exec_cnt = st_reg.exec_cnt + 16'h1;
				end
			end
			default: st_next.state = IDLE;
		endcase
		if (!st_reg.serial_output_enable_cmd)
		begin
			st_next.sout = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			st_reg <= '0;
			st_reg.state <= IDLE;
			st_reg.div <= lscu_pkg::DIV_RESET;
			st_reg.contrast <= lscu_pkg::CONTRAST_MIN;
			st_reg.standby <= 1'b1;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sout_o <= 1'b0;
			sout_oe_o <= 1'b0;
			busy_o <= 1'b0;
			standby_o <= 1'b1;
			osc_run_o <= 1'b0;
			display_on_o <= 1'b0;
			bank_o <= 1'b0;
			contrast_o <= 4'h0;
			blink_phase_o <= 1'b0;
			pointer_o <= '0;
		end
		else
		begin
			sout_o <= st_reg.sout;
			sout_oe_o <= st_reg.serial_output_enable_cmd;
			busy_o <= st_reg.state != IDLE;
			standby_o <= st_reg.standby;
			osc_run_o <= !st_reg.standby;
			display_on_o <= st_reg.disp && !st_reg.standby;
			bank_o <= st_reg.bank;
			// Offset pins shift the 0..7 count to 1..8, 2..9 or 3..10.
			contrast_o <= {1'b0, st_reg.contrast} + {2'h0, contrast_offset_i};
			blink_phase_o <= st_reg.blink_ph;
			pointer_o <= st_reg.ptr;
		end
	end
endmodule // lscu_top

/* File: tb/lscu_checker.sv */
// Port checker for the serial command unit.
// Assumes one clock domain and the active low asynchronous reset.
`timescale 1ns/1ps
module lscu_checker #(
	parameter int EXEC_TICKS = lscu_pkg::EXEC_TICKS,
	parameter int BLINK_TICKS = lscu_pkg::BLINK_TICKS
)
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic cs_i,
	input wire logic sdata_i,
	input wire logic busy_o,
	input wire logic standby_o,
	input wire logic osc_run_o,
	input wire logic sout_oe_o,
	input wire logic bank_o,
	input wire logic [3:0] contrast_o,
	input wire logic blink_phase_o,
	input wire logic [lscu_pkg::ADDR_W-1:0] pointer_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	// Standby may cut the wait short, so it counts as part of the hold.
	sequence s_busy_hold;
		(busy_o || standby_o)[*4];
	endsequence
	sequence s_busy_done;
		##[1:1000] !busy_o;
	endsequence
	a_reset_standby:
	assert property ($rose(rstn_i) |-> standby_o)
		else $error("standby missing after reset");
	a_osc_halt:
	assert property (osc_run_o == !standby_o)
		else $error("oscillator run wrong");
	a_busy_hold:
	assert property ($rose(busy_o) && !standby_o |-> s_busy_hold)
		else $error("busy too short");
	a_busy_bound:
	assert property ($rose(busy_o) |-> s_busy_done)
		else $error("busy never ends");
	a_byte_framed:
	assert property ($rose(busy_o) |-> $past(cs_i, 2))
		else $error("byte taken without select");
	a_wake_bit:
	assert property ($fell(standby_o) |-> sdata_i)
		else $error("standby left without low bit");
	a_stop_contrast:
	assert property ($rose(standby_o) |-> $stable(contrast_o))
		else $error("contrast changed on stop");
	a_stop_keeps:
	assert property ($rose(standby_o) |-> $stable(bank_o) && $stable(pointer_o))
		else $error("state lost on stop");
	a_blink_frozen:
	assert property (standby_o && $past(standby_o, 3) |-> $stable(blink_phase_o))
		else $error("blink runs in standby");
	a_oe_by_cmd:
	assert property ($rose(sout_oe_o) |-> busy_o || $past(busy_o))
		else $error("read enable without command");
endmodule // lscu_checker

bind lscu_top lscu_checker #(
	.EXEC_TICKS(EXEC_TICKS),
	.BLINK_TICKS(BLINK_TICKS)
) u_lscu_checker (
	.clk_i(clk_i), .rstn_i(rstn_i), .cs_i(cs_i), .sdata_i(sdata_i),
	.busy_o(busy_o), .standby_o(standby_o), .osc_run_o(osc_run_o),
	.sout_oe_o(sout_oe_o), .bank_o(bank_o), .contrast_o(contrast_o),
	.blink_phase_o(blink_phase_o), .pointer_o(pointer_o)
);

/* File: tb/lscu_host_model.sv */
// Host model: sends one byte, or part of one, on the serial pins.
// Assumes the bench pulses go_i for a cycle and waits for done_o.
`timescale 1ns/1ps
module lscu_host_model (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic drop_i,
	input wire logic cmd_i,
	input wire logic busy_i,
	input wire logic sout_i,
	input wire logic [3:0] nbits_i,
	input wire logic [7:0] byte_i,
	output logic cs_o,
	output logic sclk_o,
	output logic sdata_o,
	output logic cmd_sel_o,
	output logic done_o,
	output logic tmo_o,
	output logic [7:0] rdata_o
);
	// Busy is polled with a bound so a stuck device cannot hang the run.
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (3) @(posedge clk_i);
		while (busy_i !== 1'b0 && n < 3000)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 3000)
			tmo_o <= 1'b1;
	endtask

	initial
	begin
		cs_o = 1'b0;
		sclk_o = 1'b0;
		sdata_o = 1'b0;
		cmd_sel_o = 1'b0;
		done_o = 1'b0;
		tmo_o = 1'b0;
		rdata_o = 8'h00;
		forever
		begin
			@(posedge clk_i);
			if (go_i)
			begin
				wait_idle();
				cs_o <= 1'b1;
				cmd_sel_o <= cmd_i;
				for (int i = 0; i < int'(nbits_i); i++)
				begin
					sdata_o <= byte_i[7 - i];
					sclk_o <= 1'b0;
					repeat (3) @(posedge clk_i);
					sclk_o <= 1'b1;
					repeat (3) @(posedge clk_i);
					sclk_o <= 1'b0;
					repeat (3) @(posedge clk_i);
					rdata_o[7 - i] <= sout_i;
				end
				if (drop_i)
					cs_o <= 1'b0;
				wait_idle();
				done_o <= 1'b1;
				@(posedge clk_i);
				done_o <= 1'b0;
			end
		end
	end
endmodule // lscu_host_model

/* File: tb/testbench.sv */
// Self-checking bench for the serial command unit.
// Assumes the host model drives all serial pins.
`timescale 1ns/1ps
module testbench;
	logic clk_i, rstn_i, src_sel, go, drop, cmd_r;
	logic osc_tick = 1'b0;
	logic cs_w, sclk_w, sdata_w, csel_w, sout_w, soe_w, busy_w, stby_w;
	logic osc_w, disp_w, bank_w, blink_w, done_w, tmo_w;
	logic [1:0] offs;
	logic [3:0] nbits_r, cont_w;
	logic [7:0] byte_r, rdata_w;
	logic [lscu_pkg::ADDR_W-1:0] ptr_w;
	int failures, cmp_count;
	int busy_run = 0;
	int last_len = 0;

	lscu_top #(.EXEC_TICKS(4), .BLINK_TICKS(8)) u_lscu_top (
		.clk_i(clk_i), .rstn_i(rstn_i), .cs_i(cs_w), .sclk_i(sclk_w),
		.sdata_i(sdata_w), .cmd_sel_i(csel_w), .osc_tick_i(osc_tick),
		.clock_source_select_i(src_sel), .contrast_offset_i(offs),
		.sout_o(sout_w), .sout_oe_o(soe_w), .busy_o(busy_w),
		.standby_o(stby_w), .osc_run_o(osc_w), .display_on_o(disp_w),
		.bank_o(bank_w), .contrast_o(cont_w), .blink_phase_o(blink_w),
		.pointer_o(ptr_w));
	lscu_host_model u_lscu_host_model (
		.clk_i(clk_i), .go_i(go), .drop_i(drop), .cmd_i(cmd_r),
		.busy_i(busy_w), .sout_i(sout_w), .nbits_i(nbits_r),
		.byte_i(byte_r), .cs_o(cs_w), .sclk_o(sclk_w), .sdata_o(sdata_w),
		.cmd_sel_o(csel_w), .done_o(done_w), .tmo_o(tmo_w),
		.rdata_o(rdata_w));

	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// Oscillator pulse every second clock keeps divided counts short.
	always @(posedge clk_i)
	begin
		osc_tick <= ~osc_tick;
		if (busy_w === 1'b1)
			busy_run <= busy_run + 1;
		else if (busy_run != 0)
		begin
			last_len <= busy_run;
			busy_run <= 0;
		end
	end

	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_in(input int got, input int lo, input int hi);
		cmp_count++;
		if (got < lo || got > hi)
		begin
			failures++;
			$display("mismatch t=%0t got=%h max=%h", $time, got, hi);
		end
	endtask

	task automatic send(input logic [7:0] b, input logic c,
		input logic [3:0] n = 4'h8, input logic d = 1'b0);
		int k;
		@(posedge clk_i);
		byte_r <= b;
		cmd_r <= c;
		nbits_r <= n;
		drop <= d;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		k = 0;
		while (done_w !== 1'b1 && k < 9000)
		begin
			@(negedge clk_i);
			k++;
		end
		if (k >= 9000 || tmo_w === 1'b1)
		begin
			failures++;
			stop_test();
		end
	endtask

	task automatic t_wake();
		int n;
		logic ph;
		chk(stby_w, 1);
		chk(osc_w, 0);
		send(8'hc1, 1'b1);
		chk(stby_w, 0);
		chk(ptr_w, 1);
		chk(cont_w, 1);
		n = 0;
		ph = blink_w;
		repeat (64)
		begin
			@(posedge clk_i);
			if (blink_w !== ph)
				n++;
			ph = blink_w;
		end
		chk_in(n, 7, 9);
		$display("t_wake done");
	endtask

	task automatic t_ops();
		send(8'hc0, 1'b1);
		for (int i = 0; i < 8; i++)
		begin
			send({4'h0, 3'(i), 1'b0}, 1'b1);
			chk(ptr_w, 8'(i + 1));
		end
		send(8'h41, 1'b0);
		chk(ptr_w, 9);
		send(8'h89, 1'b1);
		chk(ptr_w, 9);
		chk(disp_w, 1);
		send(8'hff, 1'b1);
		send(8'h30, 1'b0);
		chk(ptr_w, 0);
		send(8'h8a, 1'b1);
		chk(ptr_w, 1);
		$display("t_ops done");
	endtask

	task automatic t_freq();
		int per;
		@(posedge clk_i);
		src_sel <= 1'b0;
		for (int c = 0; c < 4; c++)
		begin
			send(8'ha0 | 8'(c), 1'b1);
			send(8'h8a, 1'b1);
			per = 4 << c;
			chk_in(last_len, 2 * per, 5 * per + 6);
		end
		@(posedge clk_i);
		src_sel <= 1'b1;
		$display("t_freq done");
	endtask

	task automatic t_read();
		send(8'hc8, 1'b1);
		send(8'h5a, 1'b0);
		send(8'hc8, 1'b1);
		send(8'h87, 1'b1);
		chk(soe_w, 1);
		send(8'h89, 1'b1);
		chk(rdata_w, 8'h5a);
		send(8'h89, 1'b1, 4'h4, 1'b1);
		send(8'h89, 1'b1);
		chk(rdata_w, 8'ha0);
		$display("t_read done");
	endtask

	task automatic t_stop();
		logic [7:0] p;
		send(8'h83, 1'b1);
		send(8'h83, 1'b1);
		chk(cont_w, 3);
		send(8'h81, 1'b1);
		p = 8'(ptr_w);
		send(8'h84, 1'b1);
		chk(stby_w, 1);
		chk(cont_w, 3);
		chk(bank_w, 1);
		chk(ptr_w, p);
		send(8'h41, 1'b0);
		chk(stby_w, 0);
		chk(ptr_w, p + 8'h01);
		@(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(negedge clk_i);
		chk(stby_w, 1);
		send(8'h89, 1'b1);
		chk(cont_w, 1);
		$display("t_stop done");
	endtask

	initial
	begin
		rstn_i = 1'b0;
		src_sel = 1'b1;
		offs = 2'h1;
		go = 1'b0;
		drop = 1'b0;
		cmd_r = 1'b0;
		byte_r = 8'h00;
		nbits_r = 4'h8;
		failures = 0;
		cmp_count = 0;
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(negedge clk_i);
		t_wake();
		t_ops();
		t_freq();
		t_read();
		t_stop();
		stop_test();
	end
endmodule // testbench
